// [bench/uop_tagging_precise_sampling_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// bench for the tagging and sampling unit
module uop_tagging_precise_sampling_tb_top;
   logic core_clk, sys_rst, initReq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic execEventHit, replayTagOut, memReady, smmEnter, machineCheck, otherSampleIrq, slow;
   logic branchTraceIrq, dsVectorIrq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [3:0] s_axi_wstrb, replayEventType, replayUopType, execTagOut;
   logic [7:0] s_axi_awaddr, s_axi_araddr, nWords;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, addr0;
   logic [31:0] dataQ [0:31];
   uts_pkg::uts_retire_t retireUop;
   uts_pkg::uts_arch_t archState;
   uts_pkg::uts_memwr_t memWr;
   int fails, samples_checked;
   uts_top i_uts_top (.core_clk, .sys_rst, .initReq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .execEventHit, .replayEventType, .replayUopType,
      .execTagOut, .replayTagOut, .retireUop, .archState, .memReady, .memWr, .smmEnter,
      .machineCheck, .otherSampleIrq, .branchTraceIrq, .dsVectorIrq);
   uts_mem_model i_uts_mem_model (.core_clk, .sys_rst, .slow, .memWr, .memReady, .nWords,
      .addr0, .dataQ);
   always #5 core_clk = ~core_clk; // 100 MHz
   // ===========================================
   // compare, bus cycles, retirement
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task ret(input logic [3:0] t);
      @(posedge core_clk);
      retireUop <= '{1'b1, t, 1'b1, 1'b0};
      @(posedge core_clk);
      retireUop <= '0;
   endtask
   // ===========================================
   // scenarios
   task t_ident;
      rdr(8'h3C); chk("feature", rd & 32'h20_0000, 32'h20_0000);
      rdr(8'h10); chk("absent", rd & 32'h1000, 32'h0);
      rdr(8'h40); chk("unmapped", {30'h0, rr}, 32'h2);
      $display("test ident done");
   endtask
   task t_tag;
      wr(8'h00, 32'h70); // tag on, value 3
      @(posedge core_clk); execEventHit <= 1'b1;
      @(posedge core_clk); execEventHit <= 1'b0;
      @(posedge core_clk); chk("tag", {28'h0, execTagOut}, 32'h3);
      wr(8'h04, 32'h3F0); // mask 1, junk tag fields
      ret(4'h2); ret(4'h1); ret(4'h3);
      wr(8'h04, 32'h7F0); // mask 3
      ret(4'h3); ret(4'h4); ret(4'h2);
      rdr(8'h30); chk("tally", rd, 32'h4);
      $display("test tag done");
   endtask
   task t_sample;
      wr(8'h1C, 32'h1000); wr(8'h20, 32'h1050); wr(8'h24, 32'h1028); wr(8'h28, 32'hFFFF_FFFF);
      wr(8'h08, 32'h0100_0000); // sampling on, exec class
      wr(8'h2C, 32'hFFFF_FFFF);
      for (int i = 1; i <= 3; i++) begin
         slow <= (i == 2);
         ret(4'h1);
         for (int k = 0; k < 60 && nWords < 8'(10 * i); k++) @(posedge core_clk);
         repeat (4) @(posedge core_clk);
         chk("words", {24'h0, nWords}, (i < 3) ? 10 * i : 20);
         rdr(8'h1C); chk("index", rd, (i < 3) ? 32'h1000 + 40 * i : 32'h1050);
         rdr(8'h2C); chk("reload", rd, 32'hFFFF_FFFF);
      end
      chk("addr", addr0, 32'h1000); chk("gpr", dataQ[0], 32'hA0);
      chk("flags", dataQ[8], 32'h246); chk("ip", dataQ[19], 32'h40_1000);
      rdr(8'h38); chk("near", rd & 32'h1, 32'h1);
      chk("vector", {31'h0, dsVectorIrq}, 32'h1);
      $display("test sample done");
   endtask
   task t_stop;
      wr(8'h0C, 32'h1); {replayUopType, replayEventType} <= 8'h11;
      for (int j = 0; j < 2; j++) begin
         wr(8'h08, 32'h0100_0001);
         @(posedge core_clk); {smmEnter, machineCheck} <= j ? 2'b01 : 2'b10;
         @(posedge core_clk); {smmEnter, machineCheck} <= 2'b00;
         rdr(8'h08); chk("enable", rd & 32'h0100_0000, 32'h0);
         chk("replay", {31'h0, replayTagOut}, 32'h1);
      end
      rdr(8'h34); chk("rtally", rd, 32'h9);
      initReq <= 1'b1; @(posedge core_clk) initReq <= 1'b0;
      rdr(8'h08); chk("init", rd, 32'h0);
      $display("test stop done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog well beyond the expected few hundred cycles
   initial begin
      #100us;
      fails++;
      results;
   end
   // main sequence
   initial begin
      {core_clk, sys_rst, fails, samples_checked} = {2'b01, 64'h0};
      {initReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {execEventHit, smmEnter, machineCheck, otherSampleIrq, branchTraceIrq, slow} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, replayEventType, replayUopType} = '0;
      s_axi_wstrb = 4'hF;
      retireUop = '0;
      for (int i = 0; i < 8; i++) archState.gpr[i] = 32'hA0 + i;
      {archState.flags, archState.ip} = {32'h246, 32'h40_1000};
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_ident; t_tag; t_sample; t_stop;
      results;
   end
endmodule
`default_nettype wire

// [bench/uts_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// record memory: takes words, may stall
module uts_mem_model (
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic                slow,
   input  wire uts_pkg::uts_memwr_t memWr,
   output var  logic                memReady,
   output var  logic [7:0]          nWords,
   output var  logic [31:0]         addr0,
   output var  logic [31:0]         dataQ [0:31]
);
   logic stall_ff; // every other cycle refused when slow
   assign memReady = ~stall_ff;
   // capture each accepted word in order
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stall_ff <= 1'b0;
         nWords <= 8'h00;
         addr0 <= 32'h0;
      end else begin
         stall_ff <= slow & ~stall_ff;
         if (memWr.valid && memReady) begin
            dataQ[nWords[4:0]] <= memWr.data;
            if (nWords == 8'h00) addr0 <= memWr.addr;
            nWords <= nWords + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [core/uts_params.svh]
// Contract
// [RULE_01] upstream select bits 5-8 give execution tag
// [RULE_02] software sets upstream bit 4 to tag
// [RULE_03] each set mask bit tags the micro-op
// [RULE_04] downstream mask hit counts exactly one
// [RULE_05] downstream tag enable and value ignored
// [RULE_06] four tag bits count four events
// [RULE_07] multiple tag or mask bits, any match
// [RULE_08] software sets matrix, event, bit 24
// [RULE_09] replay tags count without bits 24/25
// [RULE_10] software counts replay via replay event
// [RULE_11] overflow stores registers, flags, pointer
// [RULE_12] after record reload counter and resume
// [RULE_13] interrupt when buffer nearly full
// [RULE_14] buffer never wraps, writes stop
// [RULE_15] only counter four, three event classes
// [RULE_16] feature bit 21 reports debug store
// [RULE_17] absent flag reads clear
// [RULE_18] bit 24 turns precise sampling on/off
// [RULE_19] area pointer writable, holds address
// [RULE_20] software fills buffer fields, then enables
// [RULE_21] one shared interrupt vector
// [RULE_22] disabled on system mode, machine check
// [RULE_23] tagging mechanisms stay independent
// [RULE_24] index advances, threshold irq, stop at max
`ifndef UTS_PARAMS_SVH
`define UTS_PARAMS_SVH
// =====================================================
// register byte offsets
`define UTS_OFS_UPSEL   8'h00
`define UTS_OFS_DNSEL   8'h04
`define UTS_OFS_PSEN    8'h08
`define UTS_OFS_MATRIX  8'h0C
`define UTS_OFS_MISC    8'h10
`define UTS_OFS_DSPTR   8'h14
`define UTS_OFS_BASE    8'h18
`define UTS_OFS_INDEX   8'h1C
`define UTS_OFS_ABSMAX  8'h20
`define UTS_OFS_THRESH  8'h24
`define UTS_OFS_CNTRST  8'h28
`define UTS_OFS_CNT4    8'h2C
`define UTS_OFS_EXTALLY 8'h30
`define UTS_OFS_RPTALLY 8'h34
`define UTS_OFS_STATUS  8'h38
`define UTS_OFS_FEAT    8'h3C
// =====================================================
// field positions
`define UTS_TAGEN_BIT   4
`define UTS_TAGVAL_LO   5
`define UTS_MASK_LO     9
`define UTS_PSON_BIT    24
`define UTS_PSALT_BIT   25
`define UTS_CLASS_LO    8
`define UTS_ABSENT_BIT  12
`define UTS_FEAT_BIT    21
// =====================================================
// reset values and record layout
`define UTS_RST_WORD    32'h0000_0000
`define UTS_REC_WORDS   4'hA
`define UTS_REC_BYTES   32'h0000_0028
`define UTS_RESP_OKAY   2'h0
`define UTS_RESP_SLVERR 2'h2
`endif

// [core/uts_pkg.sv]
package uts_pkg;
   // retiring micro-op and its tag bits
   typedef struct packed {
      logic       valid;
      logic [3:0] execTags;
      logic       replayTag;
      logic       frontTag;
   } uts_retire_t;
   // architectural state snapshot for a record
   typedef struct packed {
      logic [7:0][31:0] gpr;
      logic [31:0]      flags;
      logic [31:0]      ip;
   } uts_arch_t;
   // one memory write word
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [31:0] data;
   } uts_memwr_t;
   // sampling sequencer
   typedef enum logic [1:0] {ST_COUNT, ST_STORE, ST_RELOAD} uts_state_t;
endpackage

// [core/uts_record_writer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uts_params.svh"
// streams one record of words to memory
module uts_record_writer (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              start,
   input  wire logic [31:0]       baseAddr,
   input  wire uts_pkg::uts_arch_t snap,
   input  wire logic              memReady,
   output var  uts_pkg::uts_memwr_t memWr,
   output var  logic              done
);
   logic [3:0]  wordIdx_ff;   // word being offered
   logic        busy_ff;      // record in flight
   logic [31:0] word;         // selected record word
   logic        lastTake;     // final word accepted
   // word order: eight registers, flags, pointer
   assign word = (wordIdx_ff < 4'h8) ? snap.gpr[wordIdx_ff[2:0]]
               : (wordIdx_ff == 4'h8) ? snap.flags : snap.ip;
   assign lastTake = busy_ff && memReady && (wordIdx_ff == `UTS_REC_WORDS - 4'h1);
   assign memWr = {busy_ff, baseAddr + {26'h0, wordIdx_ff, 2'h0}, word};
   // sequence the words
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_ff    <= 1'b0;
         wordIdx_ff <= 4'h0;
         done       <= 1'b0;
      end else begin
         done <= lastTake;
         if (start && !busy_ff && !done) begin // not again while done
            busy_ff    <= 1'b1;
            wordIdx_ff <= 4'h0;
         end else if (lastTake) begin
            busy_ff <= 1'b0;
         end else if (busy_ff && memReady) begin
            wordIdx_ff <= wordIdx_ff + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [core/uts_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uts_params.svh"
// micro-op tagging and precise sampling unit
module uts_top (
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   input  wire logic               initReq,
   // register bus
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output var  logic               s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output var  logic               s_axi_wready,
   output var  logic [1:0]         s_axi_bresp,
   output var  logic               s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output var  logic               s_axi_arready,
   output var  logic [31:0]        s_axi_rdata,
   output var  logic [1:0]         s_axi_rresp,
   output var  logic               s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // execution and replay tagging
   input  wire logic               execEventHit,
   input  wire logic [3:0]         replayEventType,
   input  wire logic [3:0]         replayUopType,
   output var  logic [3:0]         execTagOut,
   output var  logic               replayTagOut,
   // retirement
   input  wire uts_pkg::uts_retire_t retireUop,
   input  wire uts_pkg::uts_arch_t   archState,
   // record memory port
   input  wire logic               memReady,
   output var  uts_pkg::uts_memwr_t memWr,
   // system events and shared vector
   input  wire logic               smmEnter,
   input  wire logic               machineCheck,
   input  wire logic               otherSampleIrq,
   input  wire logic               branchTraceIrq,
   output var  logic               dsVectorIrq
);
   // =====================================================
   // registers
   logic [31:0] upSel_ff;      // upstream event select
   logic [31:0] dnSel_ff;      // downstream event select
   logic [31:0] psEn_ff;       // precise sampling enable
   logic [31:0] matrix_ff;     // replay matrix
   logic [31:0] dsPtr_ff;      // save area pointer
   logic [31:0] base_ff;       // record buffer base
   logic [31:0] index_ff;      // next record address
   logic [31:0] absMax_ff;     // buffer limit
   logic [31:0] thresh_ff;     // interrupt threshold
   logic [31:0] cntRst_ff;     // counter reload value
   logic [31:0] cnt4_ff;       // queue_counter_four
   logic [31:0] exTally_ff;    // execution retired tally
   logic [31:0] rpTally_ff;    // replay retired tally
   logic        nearFull_ff;   // threshold reached
   logic        stopped_ff;    // buffer limit hit
   uts_pkg::uts_state_t state_ff;
   uts_pkg::uts_arch_t  snap_ff; // state captured at overflow
   // =====================================================
   // bus slave state
   logic        awHeld_ff;     // write address taken
   logic        wHeld_ff;      // write data taken
   logic [7:0]  awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0]  wStrb_ff;
   // =====================================================
   // decode wires
   wire         clr = initReq;                 // init acts as clear
   wire         awTake = s_axi_awvalid && s_axi_awready;
   wire         wTake = s_axi_wvalid && s_axi_wready;
   wire         arTake = s_axi_arvalid && s_axi_arready;
   wire         doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
   wire [31:0]  strbMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
                            {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
   wire         psOn = psEn_ff[`UTS_PSON_BIT];
   wire [3:0]   tagVal = upSel_ff[`UTS_TAGVAL_LO +: 4];
   wire [3:0]   tagSel = dnSel_ff[`UTS_MASK_LO +: 4];
   wire [1:0]   evClass = psEn_ff[`UTS_CLASS_LO +: 2];
   wire         exHit = retireUop.valid && |(retireUop.execTags & tagSel);
   wire         rpHit = retireUop.valid && retireUop.replayTag;
   wire         feHit = retireUop.valid && retireUop.frontTag;
   wire         classHit = (evClass == 2'h0) ? exHit
                         : (evClass == 2'h1) ? feHit
                         : (evClass == 2'h2) ? rpHit : 1'b0;
   wire         cntInc = classHit && (state_ff == uts_pkg::ST_COUNT);
   wire         overflow = cntInc && (cnt4_ff == 32'hFFFF_FFFF);
   wire         roomLeft = (index_ff + `UTS_REC_BYTES) <= absMax_ff;
   wire         recDone;
   wire         sysOff = smmEnter || machineCheck;
   wire [31:0]  nxt_index = index_ff + `UTS_REC_BYTES;
   wire         wrHit = doWrite;
   // =====================================================
   // read mux
   logic [31:0] rdWord;
   logic        rdOk;
   always_comb begin
      rdOk   = 1'b1;
      rdWord = `UTS_RST_WORD;
      case (s_axi_araddr)
         `UTS_OFS_UPSEL:   rdWord = upSel_ff;
         `UTS_OFS_DNSEL:   rdWord = dnSel_ff;
         `UTS_OFS_PSEN:    rdWord = psEn_ff;
         `UTS_OFS_MATRIX:  rdWord = matrix_ff;
         `UTS_OFS_MISC:    rdWord = `UTS_RST_WORD; // absent flag clear [RULE_17]
         `UTS_OFS_DSPTR:   rdWord = dsPtr_ff;
         `UTS_OFS_BASE:    rdWord = base_ff;
         `UTS_OFS_INDEX:   rdWord = index_ff;
         `UTS_OFS_ABSMAX:  rdWord = absMax_ff;
         `UTS_OFS_THRESH:  rdWord = thresh_ff;
         `UTS_OFS_CNTRST:  rdWord = cntRst_ff;
         `UTS_OFS_CNT4:    rdWord = cnt4_ff;
         `UTS_OFS_EXTALLY: rdWord = exTally_ff;
         `UTS_OFS_RPTALLY: rdWord = rpTally_ff;
         `UTS_OFS_STATUS:  rdWord = {30'h0, stopped_ff, nearFull_ff};
         `UTS_OFS_FEAT:    rdWord = 32'h1 << `UTS_FEAT_BIT; // [RULE_16]
         default:          rdOk   = 1'b0;
      endcase
   end
   // =====================================================
   // write address and data capture, either order
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         awHeld_ff     <= 1'b0;
         wHeld_ff      <= 1'b0;
         awAddr_ff     <= 8'h00;
         wData_ff      <= 32'h0000_0000;
         wStrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_ff && !awTake;
         s_axi_wready  <= !wHeld_ff && !wTake;
         if (awTake) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_ff <= 1'b0;
         end
         if (wTake) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_ff <= 1'b0;
         end
      end
   end
   // write response
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `UTS_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr_ff > `UTS_OFS_FEAT || awAddr_ff[1:0] != 2'h0)
                         ? `UTS_RESP_SLVERR : `UTS_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // read channel
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `UTS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !arTake;
         if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdWord;
            s_axi_rresp  <= rdOk ? `UTS_RESP_OKAY : `UTS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // =====================================================
   // software configuration registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         upSel_ff  <= `UTS_RST_WORD;
         dnSel_ff  <= `UTS_RST_WORD;
         matrix_ff <= `UTS_RST_WORD;
         dsPtr_ff  <= `UTS_RST_WORD;
         base_ff   <= `UTS_RST_WORD;
         absMax_ff <= `UTS_RST_WORD;
         thresh_ff <= `UTS_RST_WORD;
         cntRst_ff <= `UTS_RST_WORD;
      end else if (clr) begin
         upSel_ff  <= `UTS_RST_WORD;
         dnSel_ff  <= `UTS_RST_WORD;
         matrix_ff <= `UTS_RST_WORD;
         dsPtr_ff  <= `UTS_RST_WORD;
         base_ff   <= `UTS_RST_WORD;
         absMax_ff <= `UTS_RST_WORD;
         thresh_ff <= `UTS_RST_WORD;
         cntRst_ff <= `UTS_RST_WORD;
      end else if (wrHit) begin
         case (awAddr_ff)
            `UTS_OFS_UPSEL:  upSel_ff  <= (upSel_ff & ~strbMask) | (wData_ff & strbMask);
            `UTS_OFS_DNSEL:  dnSel_ff  <= (dnSel_ff & ~strbMask) | (wData_ff & strbMask);
            `UTS_OFS_MATRIX: matrix_ff <= (matrix_ff & ~strbMask) | (wData_ff & strbMask);
            `UTS_OFS_DSPTR:  dsPtr_ff  <= (dsPtr_ff & ~strbMask) | (wData_ff & strbMask); // [RULE_19]
            `UTS_OFS_BASE:   base_ff   <= (base_ff & ~strbMask) | (wData_ff & strbMask);
            `UTS_OFS_ABSMAX: absMax_ff <= (absMax_ff & ~strbMask) | (wData_ff & strbMask);
            `UTS_OFS_THRESH: thresh_ff <= (thresh_ff & ~strbMask) | (wData_ff & strbMask);
            `UTS_OFS_CNTRST: cntRst_ff <= (cntRst_ff & ~strbMask) | (wData_ff & strbMask);
            default:         upSel_ff  <= upSel_ff;
         endcase
      end
   end
   // enable register, forced off by system mode or machine check
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         psEn_ff <= `UTS_RST_WORD;
      end else if (clr) begin
         psEn_ff <= `UTS_RST_WORD;
      end else if (sysOff) begin
         psEn_ff[`UTS_PSON_BIT] <= 1'b0; // [RULE_22]
      end else if (wrHit && awAddr_ff == `UTS_OFS_PSEN) begin
         psEn_ff <= (psEn_ff & ~strbMask) | (wData_ff & strbMask); // [RULE_18]
      end
   end
   // =====================================================
   // tagging at execution
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         execTagOut   <= 4'h0;
         replayTagOut <= 1'b0;
      end else begin
         // each set tag value bit becomes a tag bit [RULE_01] [RULE_03] [RULE_07]
         execTagOut   <= (execEventHit && upSel_ff[`UTS_TAGEN_BIT]) ? tagVal : 4'h0;
         // uop type and event type both must match [RULE_09]
         replayTagOut <= |(replayUopType & matrix_ff[3:0])
                         && |(replayEventType & psEn_ff[3:0]);
      end
   end
   // =====================================================
   // retirement tallies, each mechanism alone [RULE_23]
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         exTally_ff <= `UTS_RST_WORD;
         rpTally_ff <= `UTS_RST_WORD;
      end else if (clr) begin
         exTally_ff <= `UTS_RST_WORD;
         rpTally_ff <= `UTS_RST_WORD;
      end else begin
         // any selected tag adds exactly one [RULE_04] [RULE_05] [RULE_06]
         if (exHit) begin
            exTally_ff <= exTally_ff + 32'h1;
         end
         if (rpHit) begin
            rpTally_ff <= rpTally_ff + 32'h1; // [RULE_09]
         end
      end
   end
   // =====================================================
   // sampling sequencer on counter four [RULE_15]
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= uts_pkg::ST_COUNT;
         cnt4_ff  <= `UTS_RST_WORD;
         snap_ff  <= '0;
      end else if (clr) begin
         state_ff <= uts_pkg::ST_COUNT;
         cnt4_ff  <= `UTS_RST_WORD;
      end else if (wrHit && awAddr_ff == `UTS_OFS_CNT4) begin
         cnt4_ff <= wData_ff;
      end else begin
         case (state_ff)
            uts_pkg::ST_COUNT: begin
               if (overflow && psOn && roomLeft && !stopped_ff) begin
                  state_ff <= uts_pkg::ST_STORE; // [RULE_11]
                  snap_ff  <= archState;
               end else if (overflow && psOn) begin
                  state_ff <= uts_pkg::ST_RELOAD; // full: no write [RULE_14]
               end else if (cntInc) begin
                  cnt4_ff <= cnt4_ff + 32'h1;
               end
            end
            uts_pkg::ST_STORE: begin
               if (recDone) begin
                  state_ff <= uts_pkg::ST_RELOAD;
               end
            end
            uts_pkg::ST_RELOAD: begin
               cnt4_ff  <= cntRst_ff; // [RULE_12]
               state_ff <= uts_pkg::ST_COUNT;
            end
            default: state_ff <= uts_pkg::ST_COUNT;
         endcase
      end
   end
   // =====================================================
   // buffer index and flags [RULE_24]
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         index_ff    <= `UTS_RST_WORD;
         nearFull_ff <= 1'b0;
         stopped_ff  <= 1'b0;
      end else if (clr) begin
         index_ff    <= `UTS_RST_WORD;
         nearFull_ff <= 1'b0;
         stopped_ff  <= 1'b0;
      end else begin
         if (recDone) begin
            index_ff <= nxt_index; // [RULE_24]
         end else if (wrHit && awAddr_ff == `UTS_OFS_INDEX) begin
            index_ff <= wData_ff;
         end
         // set wins over software clear
         if (recDone && nxt_index >= thresh_ff) begin
            nearFull_ff <= 1'b1; // [RULE_13]
         end else if (wrHit && awAddr_ff == `UTS_OFS_STATUS && wData_ff[0]) begin
            nearFull_ff <= 1'b0;
         end
         if (overflow && psOn && !roomLeft) begin
            stopped_ff <= 1'b1; // [RULE_14]
         end else if (wrHit && awAddr_ff == `UTS_OFS_STATUS && wData_ff[1]) begin
            stopped_ff <= 1'b0;
         end
      end
   end
   // shared vector for all sampling sources [RULE_21]
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dsVectorIrq <= 1'b0;
      end else begin
         dsVectorIrq <= nearFull_ff || otherSampleIrq || branchTraceIrq;
      end
   end
   // =====================================================
   // record writer
   uts_record_writer u_writer (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .start    (state_ff == uts_pkg::ST_STORE),
      .baseAddr (index_ff),
      .snap     (snap_ff),
      .memReady (memReady),
      .memWr    (memWr),
      .done     (recDone)
   );
   // =====================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_store;
      state_ff == uts_pkg::ST_STORE;
   endsequence
   sequence s_reload;
      state_ff == uts_pkg::ST_RELOAD ##1 cnt4_ff == $past(cntRst_ff);
   endsequence
   a_exec_tag_out: assert property ( // [RULE_01]
      execEventHit && upSel_ff[4] |=> execTagOut == $past(tagVal))
      else $error("tag value not attached");
   a_tag_gate_off: assert property ( // [RULE_02]
      !upSel_ff[4] |=> execTagOut == 4'h0)
      else $error("tag set while disabled");
   a_tally_one: assert property ( // [RULE_04]
      exHit && !clr |=> exTally_ff == $past(exTally_ff) + 32'h1)
      else $error("tally not by one");
   a_tally_hold: assert property ( // [RULE_23]
      !exHit && !clr |=> exTally_ff == $past(exTally_ff))
      else $error("tally moved without hit");
   a_replay_tally: assert property ( // [RULE_09]
      rpHit && !clr |=> rpTally_ff == $past(rpTally_ff) + 32'h1)
      else $error("replay tally missed");
   a_overflow_store: assert property ( // [RULE_11]
      state_ff == uts_pkg::ST_COUNT && overflow && psOn && roomLeft
      && !stopped_ff && !clr && !wrHit |=> s_store)
      else $error("no store on overflow");
   a_reload_after: assert property ( // [RULE_12]
      state_ff == uts_pkg::ST_STORE && recDone && !clr && !wrHit |=> s_reload)
      else $error("counter not reloaded");
   a_index_step: assert property ( // [RULE_24]
      recDone && !clr |=> index_ff == $past(index_ff) + 32'h28)
      else $error("index not advanced");
   a_near_full: assert property ( // [RULE_13]
      recDone && nxt_index >= thresh_ff && !clr |=> nearFull_ff ##1 dsVectorIrq)
      else $error("nearly full not raised");
   a_no_wrap: assert property ( // [RULE_14]
      memWr.valid |-> memWr.addr < absMax_ff)
      else $error("write past limit");
   a_sys_off: assert property ( // [RULE_22]
      sysOff && !clr |=> !psOn)
      else $error("enable kept in system mode");
endmodule
`default_nettype wire
